// >>> core/trs_consts.svh
// Purpose: shared constants of the transmit rail input sampler
// Assumes: included by its bare name after the package
// Notes: rates are the link clock figures the framer must supply, in kHz
`ifndef TRS_CONSTS_SVH
`define TRS_CONSTS_SVH

`define TRS_NUM_CH 3
`define TRS_RATE_E3_KHZ 34368
`define TRS_RATE_DS3_KHZ 44736
`define TRS_RATE_STS1_KHZ 51840
`define TRS_CLK_KHZ 20000

// configuration field positions inside trs_cfg_type
`define TRS_CFG_RISE_BIT 1
`define TRS_CFG_DUAL_BIT 0

// reset values: falling edge, single rail
`define TRS_RST_RISE_EDGE 1'b0
`define TRS_RST_DUAL_RAIL 1'b0
`define TRS_RST_ENC_ENABLE 1'b1
`define TRS_RST_LINE_TIP 1'b0
`define TRS_RST_LINE_RING 1'b0

`endif

// >>> core/trs_pkg.sv
// Purpose: types of the transmit rail input sampler
// Assumes: nothing
// Notes: one configuration struct per channel
package trs_pkg;

   typedef struct packed {
      logic rise_edge;
      logic dual_rail;
   } trs_cfg_type;

   typedef struct packed {
      logic pos;
      logic neg;
   } trs_rail_type;

   typedef struct packed {
      logic tip;
      logic ring;
   } trs_line_type;

   typedef enum logic [1:0] {
      TRS_PULSE_NONE = 2'b00,
      TRS_PULSE_NEG = 2'b01,
      TRS_PULSE_POS = 2'b10,
      TRS_PULSE_BOTH = 2'b11
   } trs_pulse_type;

endpackage : trs_pkg

// >>> core/trs_sync.sv
// Purpose: three-flop level synchroniser with agreement filter
// Assumes: d is a level from another clock domain, held for several clk edges
// Notes: q follows once the second and third stage agree; reset is synchronous
`timescale 1ns/1ps

module trs_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST = '0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } trs_sync_state_type;

   trs_sync_state_type st_r;
   trs_sync_state_type st_nxt;

   always_comb begin
      st_nxt = st_r;
      st_nxt.s1 = d;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      // only the later two stages are compared; s1 may still be metastable
      if (st_r.s2 == st_r.s3) begin
         st_nxt.q = st_r.s2;
      end
      if (!rst_n) begin
         st_nxt.q = RST;
      end
   end

   always_ff @(posedge clk) begin
      st_r <= st_nxt;
   end

   assign q = st_r.q;

endmodule : trs_sync

// >>> core/trs_tx_rail_input_sampler.sv
// Purpose: three-channel transmit rail input stage, rails in, line pulse requests out
// Assumes: each channel's tx_sample_clock is its own domain; config pins are clk-domain
// Notes: line pulses are one link clock period long and run in the link domain
//   a lane holds its line pair idle until its own copy of reset has arrived
//   new config reaches a lane some sample clock periods after cfg_*_active shows it
//   the two config fields of a lane switch together once their synchronised word settles
//
// Behaviour
// R1 - framer drives each sample clock at 34.368, 44.736 or 51.84 MHz; the framer model drives all three at 31.25 MHz.
// R2 - by default both rails are captured on the falling sample clock edge.
// R3 - in host mode software picks rising or falling capture edge per channel.
// R4 - a captured one on the positive rail emits one positive line pulse; the code emits no pulse when the negative rail is also high.
// R5 - a captured one on the negative rail emits one negative line pulse; the code emits no pulse when the positive rail is also high.
// R6 - single-rail framer presents its binary stream on the positive rail only.
// R7 - single rail needs negative rail low to enable encoder; device pulls it down.
// R8 - dual rail treats negative input as negative data, paired bit for bit.
// R9 - edge choice and rail mode are held separately for each channel.
`timescale 1ns/1ps

`include "trs_consts.svh"

module trs_tx_rail_input_sampler
   import trs_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic host_mode,
   input wire logic [`TRS_NUM_CH-1:0] cfg_rise_edge,
   input wire logic [`TRS_NUM_CH-1:0] cfg_dual_rail,
   input wire logic [`TRS_NUM_CH-1:0] tx_sample_clock,
   input wire logic [`TRS_NUM_CH-1:0] tx_positive_rail_in,
   input wire logic [`TRS_NUM_CH-1:0] tx_negative_rail_in,
   output logic [`TRS_NUM_CH-1:0] line_out_tip,
   output logic [`TRS_NUM_CH-1:0] line_out_ring,
   output logic [`TRS_NUM_CH-1:0] encoder_enable,
   output logic [`TRS_NUM_CH-1:0] cfg_rise_active,
   output logic [`TRS_NUM_CH-1:0] cfg_dual_active
);

   localparam trs_cfg_type CFG_RST = '{
      rise_edge: `TRS_RST_RISE_EDGE,
      dual_rail: `TRS_RST_DUAL_RAIL
   };

   // clk-domain state: one configuration per channel
   typedef struct packed {
      trs_cfg_type [`TRS_NUM_CH-1:0] cfg;
   } trs_host_state_type;

   trs_host_state_type host_r;
   trs_host_state_type host_nxt;
   logic [`TRS_NUM_CH-1:0] enc_link;

   // edge select only takes effect in host mode, else falling edge holds
   function automatic trs_cfg_type trs_pick_cfg(input logic hmode, input logic rise,
                                                input logic dual);
      trs_cfg_type c;
      c.rise_edge = hmode & rise; // R3 R2
      c.dual_rail = dual;
      return c;
   endfunction : trs_pick_cfg

   // decode a captured rail pair into the pulse it asks for
   function automatic trs_pulse_type trs_decode(input trs_rail_type s);
      return trs_pulse_type'({s.pos, s.neg});
   endfunction : trs_decode

   // the idle line pair, also the reset level of both outputs
   function automatic trs_line_type trs_line_idle();
      trs_line_type ln;
      ln.tip = `TRS_RST_LINE_TIP;
      ln.ring = `TRS_RST_LINE_RING;
      return ln;
   endfunction : trs_line_idle

   // both rails of one lane as a pair; the pair is one bit of the line
   function automatic trs_rail_type trs_rails(input logic pos, input logic neg);
      trs_rail_type r;
      r.pos = pos;
      r.neg = neg;
      return r;
   endfunction : trs_rails

   // one pulse request as the tip and ring levels of the line pair
   function automatic trs_line_type trs_line_of(input trs_pulse_type p);
      trs_line_type ln;
      ln = trs_line_idle();
      case (p)
         TRS_PULSE_POS: begin
            ln.tip = 1'b1; // R4
         end
         TRS_PULSE_NEG: begin
            ln.ring = 1'b1; // R5
         end
         TRS_PULSE_NONE: begin
            ln = trs_line_idle();
         end
         // both rails high at once has no bipolar meaning, so no pulse
         TRS_PULSE_BOTH: begin
            ln = trs_line_idle();
         end
      endcase
      return ln;
   endfunction : trs_line_of

   // single rail keeps the encoder on while the negative rail is low;
   // dual rail data bypasses the encoder, so it reports off
   function automatic logic trs_enc_status(input trs_cfg_type c, input trs_rail_type s);
      logic en;
      en = ~s.neg; // R7 R6
      if (c.dual_rail) begin
         en = 1'b0;
      end
      return en;
   endfunction : trs_enc_status

   always_comb begin
      host_nxt = host_r;
      for (int i = 0; i < `TRS_NUM_CH; i++) begin
         host_nxt.cfg[i] = trs_pick_cfg(host_mode, cfg_rise_edge[i], cfg_dual_rail[i]); // R9
      end
      if (!resetn) begin
         for (int i = 0; i < `TRS_NUM_CH; i++) begin
            host_nxt.cfg[i] = CFG_RST;
         end
      end
   end

   // config pins come from host-side logic on clk, so no synchroniser is needed
   always_ff @(posedge clk) begin
      host_r <= host_nxt;
   end

   always_comb begin
      for (int i = 0; i < `TRS_NUM_CH; i++) begin
         cfg_rise_active[i] = host_r.cfg[i].rise_edge;
         cfg_dual_active[i] = host_r.cfg[i].dual_rail;
      end
   end

   // encoder enable comes back from each link domain as a level
   trs_sync #(
      .W(`TRS_NUM_CH),
      .RST({`TRS_NUM_CH{`TRS_RST_ENC_ENABLE}})
   ) u_enc_sync (
      .clk(clk),
      .rst_n(resetn),
      .d(enc_link),
      .q(encoder_enable)
   );

   // link-domain lanes, one per channel, each on its own sample clock
   for (genvar g = 0; g < `TRS_NUM_CH; g++) begin : g_lane

      // rising-edge state of one lane
      typedef struct packed {
         logic [2:0] rst_s;
         logic rstn;
         trs_cfg_type cfg_prev;
         trs_cfg_type cfg_use;
         trs_rail_type rise;
         trs_line_type line;
         logic enc;
      } trs_lane_type;

      trs_lane_type lane_r;
      trs_lane_type lane_nxt;
      trs_cfg_type link_cfg;
      trs_rail_type fall_q;
      trs_rail_type smp;

      // per-channel configuration crosses into its own link domain
      trs_sync #(
         .W(2),
         .RST(CFG_RST)
      ) u_cfg_sync (
         .clk(tx_sample_clock[g]),
         .rst_n(lane_r.rstn),
         .d(host_r.cfg[g]),
         .q(link_cfg)
      ); // R9

      // the falling capture needs a flop of its own, so no clock is muxed
      always_ff @(negedge tx_sample_clock[g]) begin
         fall_q <= trs_rails(tx_positive_rail_in[g], tx_negative_rail_in[g]); // R2
      end

      always_comb begin
         lane_nxt = lane_r;
         // reset reaches the link only while the sample clock runs
         lane_nxt.rst_s = {lane_r.rst_s[1:0], resetn};
         if (lane_r.rst_s[1] == lane_r.rst_s[2]) begin
            lane_nxt.rstn = lane_r.rst_s[2];
         end
         lane_nxt.rise = trs_rails(tx_positive_rail_in[g], tx_negative_rail_in[g]); // R3
         // both fields switch together, only once the synchronised word holds still
         lane_nxt.cfg_prev = link_cfg;
         if (link_cfg == lane_r.cfg_prev) begin
            lane_nxt.cfg_use = link_cfg; // R9
         end
         smp = lane_r.cfg_use.rise_edge ? lane_r.rise : fall_q; // R2 R3
         lane_nxt.enc = trs_enc_status(lane_r.cfg_use, smp); // R7
         lane_nxt.line = trs_line_of(trs_decode(smp)); // R4 R5 R8
         // hold the line idle until this lane's own reset has been seen
         if (!lane_r.rstn) begin
            lane_nxt.cfg_prev = CFG_RST;
            lane_nxt.cfg_use = CFG_RST;
            lane_nxt.line = trs_line_idle();
            lane_nxt.enc = `TRS_RST_ENC_ENABLE;
         end
      end

      always_ff @(posedge tx_sample_clock[g]) begin
         lane_r <= lane_nxt;
      end

      assign line_out_tip[g] = lane_r.line.tip;
      assign line_out_ring[g] = lane_r.line.ring;
      assign enc_link[g] = lane_r.enc;
   end

endmodule : trs_tx_rail_input_sampler

// >>> verif/trs_framer_model.sv
// Purpose: framer model, sample clocks and rails
// Assumes: lane_rise is each lane's capture edge
// Notes: clocks run free; data launches on the edge opposite capture
`timescale 1ns/1ps
module trs_framer_model (
   input wire logic [2:0] lane_rise,
   output logic [2:0] tx_sample_clock,
   output logic [2:0] tx_positive_rail_in,
   output logic [2:0] tx_negative_rail_in
);
   logic [15:0] sp [3];
   logic [15:0] sn [3];
   task send(input int ch, input logic [15:0] p, input logic [15:0] n);
      sp[ch] = p;
      sn[ch] = n;
   endtask : send
   for (genvar i = 0; i < 3; i++) begin : g_ch
      initial begin
         tx_sample_clock[i] = 1'b0;
         tx_positive_rail_in[i] = 1'b0;
         tx_negative_rail_in[i] = 1'b0;
         sp[i] = 16'h0000;
         sn[i] = 16'h0000;
         // odd offsets keep lane edges off the system clock edges
         #(3.3 + 5 * i);
         forever #16 tx_sample_clock[i] = ~tx_sample_clock[i];
      end
      always @(tx_sample_clock[i]) begin
         if (tx_sample_clock[i] != lane_rise[i]) begin
            tx_positive_rail_in[i] <= sp[i][0];
            tx_negative_rail_in[i] <= sn[i][0];
            sp[i] <= sp[i] >> 1;
            sn[i] <= sn[i] >> 1;
         end
      end
   end
endmodule : trs_framer_model

// >>> verif/trs_tx_monitor.sv
// Purpose: port checks of the rail input sampler
// Assumes: rails quiet while config or reset changes
// Notes: lane 0 judged at falling capture, lane 1 at rising capture
`timescale 1ns/1ps
`include "trs_consts.svh"
module trs_tx_monitor
   import trs_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic host_mode,
   input wire logic [`TRS_NUM_CH-1:0] cfg_rise_edge,
   input wire logic [`TRS_NUM_CH-1:0] cfg_dual_rail,
   input wire logic [`TRS_NUM_CH-1:0] tx_sample_clock,
   input wire logic [`TRS_NUM_CH-1:0] tx_positive_rail_in,
   input wire logic [`TRS_NUM_CH-1:0] tx_negative_rail_in,
   input wire logic [`TRS_NUM_CH-1:0] line_out_tip,
   input wire logic [`TRS_NUM_CH-1:0] line_out_ring,
   input wire logic [`TRS_NUM_CH-1:0] encoder_enable,
   input wire logic [`TRS_NUM_CH-1:0] cfg_rise_active,
   input wire logic [`TRS_NUM_CH-1:0] cfg_dual_active
);
   logic [2:0] pt;
   logic [2:0] nt;
   assign pt = tx_positive_rail_in & ~tx_negative_rail_in;
   assign nt = tx_negative_rail_in & ~tx_positive_rail_in;
   AST_CFG_RISE: assert property (@(posedge clk) disable iff (!resetn)
      $past(resetn) |-> cfg_rise_active == $past(host_mode ? cfg_rise_edge : 3'h0))
      else $error("edge select wrong");
   AST_CFG_DUAL: assert property (@(posedge clk) disable iff (!resetn)
      $past(resetn) |-> cfg_dual_active == $past(cfg_dual_rail)) else $error("rail mode wrong");
   AST_TIP_FALL: assert property (@(negedge tx_sample_clock[0]) disable iff (!resetn)
      !cfg_rise_active[0] |-> line_out_tip[0] == $past(pt[0])) else $error("tip lane 0 wrong");
   AST_RING_FALL: assert property (@(negedge tx_sample_clock[0]) disable iff (!resetn)
      !cfg_rise_active[0] |-> line_out_ring[0] == $past(nt[0])) else $error("ring lane 0 wrong");
   AST_TIP_RISE: assert property (@(posedge tx_sample_clock[1]) disable iff (!resetn)
      cfg_rise_active[1] |-> line_out_tip[1] == $past(pt[1], 2)) else $error("tip lane 1 wrong");
   AST_RING_RISE: assert property (@(posedge tx_sample_clock[1]) disable iff (!resetn)
      cfg_rise_active[1] |-> line_out_ring[1] == $past(nt[1], 2)) else $error("ring lane 1 wrong");
   AST_ONE_POLARITY: assert property (@(posedge clk) disable iff (!resetn)
      (line_out_tip & line_out_ring) == 3'h0) else $error("both polarities at once");
   AST_ENC_DUAL: assert property (@(posedge clk) disable iff (!resetn)
      $rose(cfg_dual_active[2]) |-> ##[1:20] !encoder_enable[2]) else $error("encoder kept on");
endmodule : trs_tx_monitor

// >>> verif/tb_trs_tx_rail_input_sampler.sv
// Purpose: self-checking bench of the rail input sampler
// Assumes: the framer model supplies the sample clocks
// Notes: pulses are counted at mid-period of each lane
`timescale 1ns/1ps
module tb_trs_tx_rail_input_sampler;
   import trs_pkg::*;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic host_mode = 1'b0;
   logic [2:0] cfg_rise_edge = 3'h0;
   logic [2:0] cfg_dual_rail = 3'h0;
   logic [2:0] tx_sample_clock, tx_positive_rail_in, tx_negative_rail_in, lane_rise;
   logic [2:0] line_out_tip, line_out_ring, encoder_enable, cfg_rise_active, cfg_dual_active;
   logic [15:0] tc [3];
   logic [15:0] rc [3];
   int miscompares = 0;
   int checks = 0;
   assign lane_rise = host_mode ? cfg_rise_edge : 3'h0;
   always #25 clk = ~clk;
   trs_tx_rail_input_sampler u_trs_tx_rail_input_sampler (.*);
   trs_framer_model u_trs_framer_model (.*);
   for (genvar i = 0; i < 3; i++) begin : g_cnt
      always @(negedge tx_sample_clock[i]) begin
         tc[i] <= tc[i] + 16'(line_out_tip[i]);
         rc[i] <= rc[i] + 16'(line_out_ring[i]);
      end
   end
   task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task end_sim;
      if (miscompares == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : end_sim
   task send(input logic [47:0] p, input logic [47:0] n);
      for (int i = 0; i < 3; i++) begin
         tc[i] = 16'h0000;
         rc[i] = 16'h0000;
         u_trs_framer_model.send(i, p[16*i+:16], n[16*i+:16]);
      end
      repeat (16) @(negedge clk);
      for (int i = 0; i < 3; i++) begin
         check("tip count", tc[i], 16'($countones(p[16*i+:16] & ~n[16*i+:16])));
         check("ring count", rc[i], 16'($countones(n[16*i+:16] & ~p[16*i+:16])));
      end
   endtask : send
   task set_cfg(input logic h, input logic [2:0] r, input logic [2:0] d);
      host_mode = h;
      cfg_rise_edge = r;
      cfg_dual_rail = d;
      repeat (20) @(negedge clk);
      check("rise active", 16'(cfg_rise_active), 16'(h ? r : 3'h0));
      check("dual active", 16'(cfg_dual_active), 16'(d));
   endtask : set_cfg
   task wait_enc(input logic [2:0] exp);
      int k;
      for (k = 0; k < 40 && encoder_enable !== exp; k++) @(negedge clk);
      check("encoder enable", 16'(encoder_enable), 16'(exp));
      if (encoder_enable !== exp) end_sim;
   endtask : wait_enc
   task t_defaults;
      check("rise active", 16'(cfg_rise_active), 16'h0000);
      wait_enc(3'h7);
      send(48'h8001_0F0F_A5C3, 48'h0000_3000_0041);
   endtask : t_defaults
   task t_edges;
      set_cfg(1'b1, 3'h2, 3'h0);
      send(48'h8001_0F0F_A5C3, 48'h0000_3000_0041);
      // rise select must be ignored outside host mode
      set_cfg(1'b0, 3'h7, 3'h0);
      send(48'hFFFF_00FF_1111, 48'h0000_FF00_0000);
   endtask : t_edges
   task t_dual;
      set_cfg(1'b1, 3'h5, 3'h4);
      wait_enc(3'h3);
      send(48'hF0F0_AAAA_0001, 48'h0F0F_5555_8000);
   endtask : t_dual
   task t_enc;
      set_cfg(1'b0, 3'h0, 3'h0);
      wait_enc(3'h7);
      u_trs_framer_model.send(2, 16'h0000, 16'hFFFF);
      wait_enc(3'h3);
      repeat (20) @(negedge clk);
      wait_enc(3'h7);
   endtask : t_enc
   initial begin
      repeat (4) @(negedge clk);
      resetn = 1'b1;
      repeat (10) @(negedge clk);
      t_defaults;
      t_edges;
      t_dual;
      t_enc;
      end_sim;
   end
endmodule : tb_trs_tx_rail_input_sampler
bind trs_tx_rail_input_sampler trs_tx_monitor u_trs_tx_monitor (.*);
